// ===== cof_far_model.sv
// Far side model: closing sources, overcurrent stages and reclose sequencer
`timescale 1ns/1ps
module cof_far_model (
    input  wire       aclk,
    input  wire       aresetn,
    input  wire [5:0] close_req,       // Close orders from the bench
    input  wire [1:0] pick_req,        // Wanted pickups, bit1 third stage
    input  wire       reclaim_req,     // Wanted reclaim window
    input  wire       trip_in,         // Trip pulse toward the breaker
    output reg  [5:0] close_src,       // Closing source pins
    output reg        stage2_pickup,   // Second stage over threshold
    output reg        stage3_pickup,   // Third stage over threshold
    output reg        reclaim_running  // Sequencer reclaim window
);
    reg open_q;                        // Breaker opened by a trip

    // A trip opens the breaker so the fault current and pickups vanish
    always @(posedge aclk) begin
        if (!aresetn) begin
            close_src <= 6'h00;
            open_q <= 1'h0;
            stage2_pickup <= 1'h0;
            stage3_pickup <= 1'h0;
            reclaim_running <= 1'h0;
        end else begin
            close_src <= close_req;
            open_q <= trip_in | (open_q & ~|close_req);
            stage2_pickup <= pick_req[0] & ~(trip_in | open_q);
            stage3_pickup <= pick_req[1] & ~(trip_in | open_q);
            reclaim_running <= reclaim_req;
        end
    end
endmodule // cof_far_model

// ===== cof_map.vh
// Register map, field positions, reset values and timing for the close-onto-fault block
`ifndef COF_MAP_VH
`define COF_MAP_VH

// Clock rate and fixed arming time
`define COF_CLK_HZ          25000000
`define COF_ARM_TIME_MS     500
`define COF_MS_CYCLES       (`COF_CLK_HZ / 1000)

// Register byte offsets
`define COF_OFF_CTRL        8'h00
`define COF_OFF_DELAY       8'h04
`define COF_OFF_STATE       8'h08
`define COF_OFF_IRQ_STAT    8'h0C
`define COF_OFF_IRQ_CLR     8'h10
`define COF_OFF_IRQ_EN      8'h14

// Control register fields
`define COF_CTRL_EN_BIT     0
`define COF_CTRL_SRC_LSB    1
`define COF_CTRL_SRC_MSB    6

// Delay register field, milliseconds
`define COF_DELAY_MSB       15

// Reset values
`define COF_CTRL_RST        32'h00000000
`define COF_DELAY_RST       32'h00000032
`define COF_IRQ_EN_RST      4'h0

// Event bits in status, clear and enable registers
`define COF_EV_TRIP         0
`define COF_EV_LOCKOUT      1
`define COF_EV_ABORT        2
`define COF_EV_ARMED        3
`define COF_EV_W            4

// AXI responses
`define COF_RESP_OKAY       2'b00
`define COF_RESP_SLVERR     2'b10

`endif

// ===== cof_props.sv
// Concurrent checks on trip, lockout, override and register bus handshakes
`timescale 1ns/1ps
module cof_props (
    input wire       aclk,
    input wire       aresetn,
    input wire       s_axi_awvalid,
    input wire       s_axi_awready,
    input wire       s_axi_wvalid,
    input wire       s_axi_wready,
    input wire       s_axi_bvalid,
    input wire       s_axi_arvalid,
    input wire       s_axi_arready,
    input wire       s_axi_rvalid,
    input wire       stage2_pickup,
    input wire       stage3_pickup,
    input wire       reclaim_running,
    input wire       close_onto_fault_trip_q,
    input wire       stage_delay_override_q,
    input wire       autoreclose_lockout_q
);
    wire trp = close_onto_fault_trip_q;       // Trip pulse
    wire ovr = stage_delay_override_q;        // Fast delay running
    wire lko = autoreclose_lockout_q;         // Reclose lockout pulse
    wire pk  = stage2_pickup | stage3_pickup; // Either stage picked up
    wire rcl = reclaim_running;               // Reclaim window open

    // One clock domain; reset silences every check
    default clocking dcb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_trip_single: assert property (trp |=> !trp)
        else $error("trip pulse lasted more than one cycle");
    chk_lockout_trip: assert property (lko |-> trp)
        else $error("lockout without a trip");
    // Steady reclaim level, so sampling order inside the block cannot matter
    chk_lockout_cause: assert property (trp && (rcl == $past(rcl)) |-> (lko == rcl))
        else $error("lockout does not follow reclaim at trip");
    chk_trip_pickup: assert property (trp |-> $past(pk))
        else $error("trip with no stage picked up");
    chk_trip_override: assert property (trp |-> $past(ovr))
        else $error("trip without the fast delay running");
    chk_override_cause: assert property ($rose(ovr) |-> $past(pk))
        else $error("fast delay started with no pickup");
    chk_abort_quiet: assert property (ovr && !pk |=> (!trp) [*2])
        else $error("trip after both pickups dropped");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response not two cycles after take");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data not one cycle after take");
endmodule // cof_props

bind cof_top cof_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .stage2_pickup, .stage3_pickup, .reclaim_running,
    .close_onto_fault_trip_q, .stage_delay_override_q, .autoreclose_lockout_q);

// ===== cof_timer.v
// Millisecond down-timer with its own prescaler, used for arming and fast-trip delays
`timescale 1ns/1ps
`include "cof_map.vh"
module cof_timer #(
    parameter TICK_CYCLES = `COF_MS_CYCLES,  // Clock cycles per millisecond
    parameter LOAD_W      = 16               // Width of the millisecond count
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire              start,          // Load and run, restarts if running
    input  wire              stop,           // Abandon without done
    input  wire [LOAD_W-1:0] load,           // Delay in milliseconds
    output reg               running_q,      // Counting
    output reg               done_q          // One-cycle pulse at expiry
);
    reg [23:0]       pre_q;                  // Prescaler toward one millisecond
    reg [LOAD_W-1:0] cnt_q;                  // Milliseconds left

    // Prescaler restarts with each start so the delay is never short
    always @(posedge aclk) begin
        if (!aresetn) begin
            pre_q     <= 24'h000000;
            cnt_q     <= {LOAD_W{1'b0}};
            running_q <= 1'b0;
            done_q    <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (stop) begin
                running_q <= 1'b0;
            end else if (start) begin
                pre_q <= 24'h000000;
                cnt_q <= load;
                // Zero delay expires on the next edge
                if (load == {LOAD_W{1'b0}}) begin
                    done_q    <= 1'b1;
                    running_q <= 1'b0;
                end else begin
                    running_q <= 1'b1;
                end
            end else if (running_q) begin
                if (pre_q == TICK_CYCLES[23:0] - 24'h000001) begin
                    pre_q <= 24'h000000;
                    cnt_q <= cnt_q - {{(LOAD_W-1){1'b0}}, 1'b1};
                    // Last millisecond gone
                    if (cnt_q == {{(LOAD_W-1){1'b0}}, 1'b1}) begin
                        done_q    <= 1'b1;
                        running_q <= 1'b0;
                    end
                end else begin
                    pre_q <= pre_q + 24'h000001;
                end
            end
        end
    end
endmodule // cof_timer

// ===== cof_top.v
// Close-onto-fault fast trip logic with its AXI4-Lite register slave
`timescale 1ns/1ps
`include "cof_map.vh"

module cof_top #(
    parameter MS_CYCLES = `COF_MS_CYCLES,    // Cycles per millisecond
    parameter ARM_MS    = `COF_ARM_TIME_MS   // Fixed arming time in ms
) (
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Closing sources, from pins
    input  wire [5:0]  close_src,
    // Overcurrent stages and reclose sequencer, same clock
    input  wire        stage2_pickup,
    input  wire        stage3_pickup,
    input  wire        reclaim_running,
    // Outputs toward breaker, stages and sequencer, and the interrupt
    output reg         close_onto_fault_trip_q,
    output reg         stage_delay_override_q,
    output reg         autoreclose_lockout_q,
    output reg         irq_q
);
    // FSM states
    localparam ST_IDLE   = 2'd0;
    localparam ST_ARMING = 2'd1;
    localparam ST_ARMED  = 2'd2;
    localparam ST_TIMING = 2'd3;

    reg  [1:0]  state_q;                     // Function state
    reg  [1:0]  state_d;
    reg  [5:0]  src_meta_q;                  // First synchroniser stage
    reg  [5:0]  src_sync_q;                  // Second synchroniser stage
    reg  [5:0]  src_prev_q;                  // For edge detection
    reg  [31:0] ctrl_q;                      // Enable and source selection
    reg  [31:0] delay_q;                     // Fast-trip delay in ms
    reg  [3:0]  irq_stat_q;                  // Sticky events
    reg  [3:0]  irq_en_q;                    // Event enables
    reg  [3:0]  irq_clr;                     // Clear strobe this cycle
    reg  [3:0]  ev;                          // Events this cycle
    reg  [7:0]  aw_addr_q;                   // Held write address
    reg         aw_have_q;
    reg  [31:0] w_data_q;                    // Held write data
    reg  [3:0]  w_strb_q;
    reg         w_have_q;
    reg         arm_start;
    reg         fast_start;
    reg         timers_stop;
    wire        arm_running;
    wire        arm_done;
    wire        fast_running;
    wire        fast_done;
    wire        enabled;
    wire        close_seen;
    wire        pickup;

    // Byte-lane merge for register writes
    function [31:0] merge_strb;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer i;
        begin
            merge_strb = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge_strb[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    // Address decode shared by read and write
    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a == `COF_OFF_CTRL) || (a == `COF_OFF_DELAY) ||
                        (a == `COF_OFF_STATE) || (a == `COF_OFF_IRQ_STAT) ||
                        (a == `COF_OFF_IRQ_CLR) || (a == `COF_OFF_IRQ_EN);
        end
    endfunction

    // Setting and input qualification
    assign enabled = ctrl_q[`COF_CTRL_EN_BIT];
    // Only newly asserted, selected sources count as a close
    assign close_seen = |(src_sync_q & ~src_prev_q
                          & ctrl_q[`COF_CTRL_SRC_MSB:`COF_CTRL_SRC_LSB]);
    assign pickup = stage2_pickup | stage3_pickup;

    // Two-flop synchroniser for the close pins
    always @(posedge aclk) begin
        if (!aresetn) begin
            src_meta_q <= 6'h00;
            src_sync_q <= 6'h00;
            src_prev_q <= 6'h00;
        end else begin
            src_meta_q <= close_src;
            src_sync_q <= src_meta_q;
            src_prev_q <= src_sync_q;
        end
    end

    // Fixed arming timer, not software adjustable
    cof_timer #(
        .TICK_CYCLES (MS_CYCLES),
        .LOAD_W      (16)
    ) u_arm_timer (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .start     (arm_start),
        .stop      (timers_stop),
        .load      (ARM_MS[15:0]),
        .running_q (arm_running),
        .done_q    (arm_done)
    );

    // Fast-trip delay timer, loaded from the delay setting
    cof_timer #(
        .TICK_CYCLES (MS_CYCLES),
        .LOAD_W      (16)
    ) u_fast_trip_delay_timer (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .start     (fast_start),
        .stop      (timers_stop),
        .load      (delay_q[`COF_DELAY_MSB:0]),
        .running_q (fast_running),
        .done_q    (fast_done)
    );

    // Next state, timer control and events
    always @* begin
        state_d     = state_q;
        arm_start   = 1'b0;
        fast_start  = 1'b0;
        timers_stop = 1'b0;
        ev          = 4'h0;
        case (state_q)
            ST_IDLE: begin
                if (enabled && close_seen) begin
                    arm_start = 1'b1;
                    state_d   = ST_ARMING;
                end
            end
            ST_ARMING: begin
                if (!enabled) begin
                    timers_stop = 1'b1;
                    state_d     = ST_IDLE;
                end else if (close_seen) begin
                    // A further close restarts the arming window
                    arm_start = 1'b1;
                end else if (arm_done) begin
                    ev[`COF_EV_ARMED] = 1'b1;
                    state_d           = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (!enabled) begin
                    state_d = ST_IDLE;
                end else if (close_seen) begin
                    arm_start = 1'b1;
                    state_d   = ST_ARMING;
                end else if (pickup) begin
                    fast_start = 1'b1;
                    state_d    = ST_TIMING;
                end
            end
            ST_TIMING: begin
                if (!enabled) begin
                    timers_stop = 1'b1;
                    state_d     = ST_IDLE;
                end else if (!pickup) begin
                    // Pickup gone before expiry: no trip, whole function resets
                    timers_stop      = 1'b1;
                    ev[`COF_EV_ABORT] = 1'b1;
                    state_d          = ST_IDLE;
                end else if (fast_done) begin
                    ev[`COF_EV_TRIP]    = 1'b1;
                    ev[`COF_EV_LOCKOUT] = reclaim_running;
                    state_d             = ST_IDLE;
                end
            end
            default: begin
                timers_stop = 1'b1;
                state_d     = ST_IDLE;
            end
        endcase
    end

    // State and function outputs, all cleared by reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q                 <= ST_IDLE;
            close_onto_fault_trip_q <= 1'b0;
            stage_delay_override_q  <= 1'b0;
            autoreclose_lockout_q   <= 1'b0;
        end else begin
            state_q                 <= state_d;
            close_onto_fault_trip_q <= ev[`COF_EV_TRIP];
            // Stage suppresses its own delay while the fast delay runs
            stage_delay_override_q  <= (state_d == ST_TIMING);
            autoreclose_lockout_q   <= ev[`COF_EV_LOCKOUT];
        end
    end

    // AXI write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `COF_RESP_OKAY;
            aw_addr_q     <= 8'h00;
            aw_have_q     <= 1'b0;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
            w_have_q      <= 1'b0;
            ctrl_q        <= `COF_CTRL_RST;
            delay_q       <= `COF_DELAY_RST;
            irq_en_q      <= `COF_IRQ_EN_RST;
            irq_clr       <= 4'h0;
        end else begin
            irq_clr <= 4'h0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_q     <= s_axi_awaddr;
                aw_have_q     <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_q     <= s_axi_wdata;
                w_strb_q     <= s_axi_wstrb;
                w_have_q     <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            // Both halves present: commit and answer
            if (aw_have_q && w_have_q && !s_axi_bvalid) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(aw_addr_q) ? `COF_RESP_OKAY : `COF_RESP_SLVERR;
                case (aw_addr_q)
                    `COF_OFF_CTRL:    ctrl_q   <= merge_strb(ctrl_q, w_data_q, w_strb_q);
                    `COF_OFF_DELAY:   delay_q  <= merge_strb(delay_q, w_data_q, w_strb_q);
                    `COF_OFF_IRQ_EN: begin
                        if (w_strb_q[0]) begin
                            irq_en_q <= w_data_q[3:0];
                        end
                    end
                    `COF_OFF_IRQ_CLR: begin
                        if (w_strb_q[0]) begin
                            irq_clr <= w_data_q[3:0];
                        end
                    end
                    default: begin
                        // Read-only or unmapped: nothing stored
                    end
                endcase
            end
            // Ready returns only after the answer is taken
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // AXI read channel, one read in flight
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `COF_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= is_mapped(s_axi_araddr) ? `COF_RESP_OKAY : `COF_RESP_SLVERR;
                case (s_axi_araddr)
                    `COF_OFF_CTRL:     s_axi_rdata <= ctrl_q;
                    `COF_OFF_DELAY:    s_axi_rdata <= delay_q;
                    `COF_OFF_STATE:    s_axi_rdata <= {26'h0000000, fast_running,
                                                       arm_running, src_sync_q[0] & 1'b0,
                                                       stage_delay_override_q, state_q};
                    `COF_OFF_IRQ_STAT: s_axi_rdata <= {28'h0000000, irq_stat_q};
                    `COF_OFF_IRQ_EN:   s_axi_rdata <= {28'h0000000, irq_en_q};
                    default:           s_axi_rdata <= 32'h00000000;
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Sticky events: a new event beats a clear in the same cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= 4'h0;
            irq_q      <= 1'b0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | ev;
            irq_q      <= |(((irq_stat_q & ~irq_clr) | ev) & irq_en_q);
        end
    end
endmodule // cof_top

// ===== cof_top_tb.sv
// Self-checking bench for the close-onto-fault block
`timescale 1ns/1ps
`include "cof_map.vh"
module cof_top_tb;
    localparam MS   = 4;                // Shortened millisecond
    localparam ARM  = 3;                // Shortened arming time, ms
    localparam ARMC = ARM * MS;         // Arming cycles
    localparam OK   = `COF_RESP_OKAY;   // Good response
    reg         aclk = 1'h0;            // Bench clock
    reg         aresetn = 1'h0;         // Synchronous reset
    reg  [7:0]  awaddr = 8'h00;         // Write address
    reg  [7:0]  araddr = 8'h00;         // Read address
    reg  [31:0] wdata = 32'h0;          // Write data
    reg         awvalid = 1'h0;         // Bus request lines
    reg         wvalid = 1'h0;
    reg         bready = 1'h0;
    reg         arvalid = 1'h0;
    reg         rready = 1'h0;
    wire        awready, wready, bvalid, arready, rvalid;
    wire [1:0]  bresp, rresp;           // Response codes
    wire [31:0] rdata;                  // Read data
    reg  [5:0]  close_req = 6'h00;      // Model commands
    reg  [1:0]  pick_req = 2'h0;
    reg         reclaim_req = 1'h0;
    wire [5:0]  close_src;              // Far side pins
    wire        s2, s3, recl, trip, ovr, lko, irq;
    integer     fail_count = 0;         // Mismatches
    integer     checked = 0;            // Comparisons
    reg         seen_trp, seen_ovr, lk_seen;

    always #20 aclk = ~aclk;

    cof_top #(.MS_CYCLES(MS), .ARM_MS(ARM)) DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .close_src(close_src),
        .stage2_pickup(s2), .stage3_pickup(s3), .reclaim_running(recl),
        .close_onto_fault_trip_q(trip), .stage_delay_override_q(ovr),
        .autoreclose_lockout_q(lko), .irq_q(irq));

    cof_far_model u_far (.aclk(aclk), .aresetn(aresetn), .close_req(close_req),
        .pick_req(pick_req), .reclaim_req(reclaim_req), .trip_in(trip),
        .close_src(close_src), .stage2_pickup(s2), .stage3_pickup(s3),
        .reclaim_running(recl));

    // Verdict and end of run
    task tally_and_finish;
        if (fail_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Compare with four-state equality so unknowns never match
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // A wait ran out of cycles
    task hang;
        chk("wait", 32'h0, 32'h1);
        tally_and_finish;
    endtask

    function [31:0] in_win(input integer v, input integer lo, input integer hi);
        in_win = (v >= lo && v <= hi) ? 32'h1 : 32'h0;
    endfunction

    // Status after a trip: trip and armed events, lockout if reclaim ran
    function [31:0] stat_exp(input integer rc);
        stat_exp = 32'h9 | (rc << 1);
    endfunction

    // Register write; a spare edge keeps bready from two drives in one step
    task axw(input [7:0] a, input [31:0] d, input [1:0] er);
        integer n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 50; n = n + 1) begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'h0;
            if (wvalid && wready)
                wvalid <= 1'h0;
            if (bvalid)
                break;
        end
        if (n == 50)
            hang;
        chk("bresp", {30'h0, bresp}, {30'h0, er});
        bready <= 1'h0;
        @(posedge aclk);
    endtask

    // Register read with expected data and response
    task axr(input [7:0] a, input [31:0] ed, input [1:0] er);
        integer n;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 50; n = n + 1) begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'h0;
            if (rvalid)
                break;
        end
        if (n == 50)
            hang;
        chk("rdata", rdata, ed);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
        rready <= 1'h0;
        @(posedge aclk);
    endtask

    // One-cycle close order on the given sources
    task pulse(input [5:0] b);
        close_req <= b;
        @(posedge aclk);
        close_req <= 6'h00;
    endtask

    // Run some cycles noting any trip or fast delay
    task watch(input integer cyc);
        seen_trp = 1'h0;
        seen_ovr = 1'h0;
        repeat (cyc) begin
            @(posedge aclk);
            if (trip === 1'h1)
                seen_trp = 1'h1;
            if (ovr === 1'h1)
                seen_ovr = 1'h1;
        end
    endtask

    // Count edges until override (0) or trip (1) is seen
    task wait_sig(input integer which, output integer n);
        for (n = 1; n <= 300; n = n + 1) begin
            @(posedge aclk);
            if (which ? trip === 1'h1 : ovr === 1'h1)
                break;
        end
        if (n > 300)
            hang;
        lk_seen = lko;
    endtask

    initial begin
        integer i, d, n, rc;
        rc = $urandom(32'hAADF854C);
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        axr(`COF_OFF_CTRL, `COF_CTRL_RST, OK);
        axr(`COF_OFF_DELAY, `COF_DELAY_RST, OK);
        axr(`COF_OFF_IRQ_EN, 32'h0, OK);
        axr(8'h1C, 32'h0, `COF_RESP_SLVERR);
        axw(8'h1C, 32'hFFFFFFFF, `COF_RESP_SLVERR);
        axw(`COF_OFF_IRQ_EN, 32'hF, OK);
        // Every source alone, random delay and reclaim state, stages in turn
        for (i = 0; i < 6; i = i + 1) begin
            d = 1 + $urandom % 3;
            rc = $urandom % 2;
            axw(`COF_OFF_DELAY, d, OK);
            axw(`COF_OFF_CTRL, 32'h1 | (32'h2 << i), OK);
            reclaim_req <= rc[0];
            pick_req <= 2'h1 << (i % 2);
            pulse(6'h1 << ((i + 1) % 6));
            watch(ARMC + 10);
            chk("unselected", {31'h0, seen_ovr}, 32'h0);
            pulse(6'h1 << i);
            wait_sig(0, n);
            chk("arming", in_win(n, ARMC + 2, ARMC + 8), 32'h1);
            wait_sig(1, n);
            chk("fast delay", in_win(n, d * MS, d * MS + 2), 32'h1);
            chk("lockout", {31'h0, lk_seen}, rc);
            @(posedge aclk);
            chk("trip width", {31'h0, trip}, 32'h0);
            repeat (2) @(posedge aclk);
            chk("irq", {31'h0, irq}, 32'h1);
            axr(`COF_OFF_IRQ_STAT, stat_exp(rc), OK);
            axw(`COF_OFF_IRQ_CLR, 32'hF, OK);
            repeat (2) @(posedge aclk);
            chk("irq clear", {31'h0, irq}, 32'h0);
            pick_req <= 2'h0;
            reclaim_req <= 1'h0;
        end
        // Pickups drop in mid delay: no trip, abort event masked then enabled
        axw(`COF_OFF_IRQ_EN, 32'h3, OK);
        axw(`COF_OFF_CTRL, 32'h7F, OK);
        pick_req <= 2'h3;
        pulse(6'h01);
        wait_sig(0, n);
        pick_req <= 2'h0;
        watch(3 * MS + 8);
        chk("abort trip", {31'h0, seen_trp}, 32'h0);
        chk("abort ovr", {31'h0, ovr}, 32'h0);
        axr(`COF_OFF_IRQ_STAT, 32'hC, OK);
        chk("irq masked", {31'h0, irq}, 32'h0);
        axw(`COF_OFF_IRQ_EN, 32'h4, OK);
        repeat (2) @(posedge aclk);
        chk("irq abort", {31'h0, irq}, 32'h1);
        axw(`COF_OFF_IRQ_CLR, 32'hF, OK);
        // Function disabled: all sources selected, nothing happens
        axw(`COF_OFF_CTRL, 32'h7E, OK);
        pick_req <= 2'h1;
        pulse(6'h3F);
        watch(ARMC + 20);
        chk("disabled", {30'h0, seen_ovr, seen_trp}, 32'h0);
        axr(`COF_OFF_STATE, 32'h0, OK);
        // Reset in mid delay clears timers and settings
        axw(`COF_OFF_CTRL, 32'h3, OK);
        pulse(6'h01);
        wait_sig(0, n);
        aresetn <= 1'h0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        chk("reset ovr", {31'h0, ovr}, 32'h0);
        axr(`COF_OFF_CTRL, `COF_CTRL_RST, OK);
        watch(ARMC + 10);
        chk("after reset", {30'h0, seen_ovr, seen_trp}, 32'h0);
        tally_and_finish;
    end
endmodule // cof_top_tb
